// ===== remote_peer.sv
/*
 * remote peer on the serial pins: echoes the nrz line back after a short wire delay.
 * assumes the same clock as the channel; the line is always driven.
 */
`timescale 1ns/1ps

module remote_peer (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// serial line
	input wire line_in,
	output reg line_out
);
	reg [2:0] delay_r;
	// nrz level returned as is, no clock line beside it
	always @(posedge core_clk) begin
		if (reset) begin
			delay_r <= 3'h0;
			line_out <= 1'b0;
		end else begin
			delay_r <= {delay_r[1:0], line_in};
			line_out <= delay_r[2];
		end
	end
endmodule // remote_peer

// ===== serial_transceiver_datapath.v
/*
 * one transceiver channel datapath: parallel words to nrz serial and back,
 * configured over classic wishbone. the core clock runs at the multiplier times the bit clock;
 * the bit clock runs once per clock-enable pulse from a divider whose ratio
 * is the programmed multiplier held to 1..25. serial input is a pin and is synchronised.
 * assumes a wishbone master on core_clk and a remote nrz peer on the pins.
 */
// Local design decisions: the Wishbone slave port and the address map.
// Operation
// - transmit serialises 16, 20, 32 or 40 bits
// - divided transmit clock marks parallel word timing
// - transmit fifo enabled or bypassed by configuration
// - selectable line encoding for transitions
// - receive deserialises to 16/20/32/40-bit words
// - receiver recovers timing from data, no clock line
// - serial data is nrz, encoding optional
// - received words handed out on receive user clock
// - bit clock is reference times multiplier, max 25; here the bit clock is core_clk divided by the multiplier
// - transmit and receive clocked independently
// - configuration writable at any time, even running
// - low-speed out-of-band signalling while link idle
// - device holds eight such channels
`timescale 1ns/1ps
`include "xcvr_consts.vh"

// one channel; the device places `LANES identical instances side by side
module serial_transceiver_datapath (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// parallel transmit side
	input wire tx_valid,
	input wire [39:0] tx_data,
	output reg tx_ready,
	output reg tx_divided_clock_out,
	// parallel receive side
	output reg [39:0] rx_data,
	output reg rx_valid,
	output reg rx_user_clock,
	// serial pins
	output reg ser_out,
	input wire ser_in
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [5:0] word_len;
		input [1:0] w;
		begin
			case (w)
				`W16: word_len = `LEN16;
				`W20: word_len = `LEN20;
				`W32: word_len = `LEN32;
				default: word_len = `LEN40;
			endcase
		end
	endfunction

	function [4:0] clamp_mult;
		input [4:0] m;
		begin
			if (m > `MULT_MAX) begin
				clamp_mult = `MULT_MAX;
			end else if (m < `MULT_MIN) begin
				clamp_mult = `MULT_MIN;
			end else begin
				clamp_mult = m;
			end
		end
	endfunction

	// whitening keeps transitions; same function undoes it on receive
	function [39:0] whiten;
		input [39:0] d;
		input [1:0] enc;
		begin
			case (enc)
				`ENC_NONE: whiten = d;
				`ENC_8B10B: whiten = d ^ {4{`WHITEN_8B10B}};
				`ENC_64B66B: whiten = d ^ {`SCRAMBLE_SEED, `SCRAMBLE_SEED, `SCRAMBLE_LOW};
				default: whiten = d ^ {`SCRAMBLE_LOW, `SCRAMBLE_SEED, `SCRAMBLE_SEED};
			endcase
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [31:0] tx_cfg_r;
	reg [31:0] rx_cfg_r;
	reg [39:0] tx_word_r;
	reg tx_word_wr_r;
	reg tx_busy_r;
	reg rx_locked_r;
	reg rx_oob_r;
	wire fifo_empty;
	wire wb_req;
	wire [31:0] wmask;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always @(posedge core_clk) begin
		if (reset) begin
			tx_cfg_r <= `CFG_RESET;
			rx_cfg_r <= `CFG_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			tx_word_r <= 40'h00_0000_0000;
			tx_word_wr_r <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			tx_word_wr_r <= 1'b0;
			if (wb_req && wb_we_i) begin
				case (wb_adr_i)
					`REG_TX_CFG: tx_cfg_r <= ((tx_cfg_r & ~wmask) | (wb_dat_i & wmask)) & `CFG_MASK;
					`REG_RX_CFG: rx_cfg_r <= ((rx_cfg_r & ~wmask) | (wb_dat_i & wmask)) & `CFG_MASK;
					`REG_TX_WORD: begin
						tx_word_r <= {8'h00, wb_dat_i};
						tx_word_wr_r <= 1'b1;
					end
					default: ;
				endcase
			end
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`REG_TX_CFG: wb_dat_o <= tx_cfg_r;
					`REG_RX_CFG: wb_dat_o <= rx_cfg_r;
					`REG_STATUS: wb_dat_o <= {28'h000_0000, rx_locked_r, fifo_empty, tx_busy_r, rx_oob_r};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// independent bit-clock dividers
	// ----------------------------------------
	reg [4:0] tx_div_r;
	reg [4:0] rx_div_r;
	wire tx_bit_en;
	wire rx_bit_en;

	assign tx_bit_en = (tx_div_r == 5'h00);
	assign rx_bit_en = (rx_div_r == 5'h00);

	always @(posedge core_clk) begin
		if (reset) begin
			tx_div_r <= 5'h00;
			rx_div_r <= 5'h00;
		end else begin
			tx_div_r <= tx_bit_en ? clamp_mult(tx_cfg_r[`F_MULT_HI:`F_MULT_LO]) - 1'b1 : tx_div_r - 1'b1;
			rx_div_r <= rx_bit_en ? clamp_mult(rx_cfg_r[`F_MULT_HI:`F_MULT_LO]) - 1'b1 : rx_div_r - 1'b1;
		end
	end

	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	wire tx_fifo_en;
	wire fifo_ready;
	wire [39:0] fifo_q;
	wire [39:0] tx_src_mux;
	wire [39:0] tx_load_word;
	reg fifo_q_ok_r;
	reg fifo_take_r;
	reg [39:0] tx_shift_r;
	reg [5:0] tx_cnt_r;
	reg [7:0] oob_cnt_r;
	wire [5:0] tx_len;
	wire tx_load;
	wire in_valid;
	wire [39:0] in_data;

	assign tx_fifo_en = tx_cfg_r[`F_FIFO_EN];
	assign tx_len = word_len(tx_cfg_r[`F_WIDTH_HI:`F_WIDTH_LO]);
	assign in_valid = tx_valid | tx_word_wr_r;
	assign in_data = tx_word_wr_r ? tx_word_r : tx_data;
	assign tx_load = tx_bit_en && (tx_cnt_r == 6'h00) && tx_cfg_r[`F_ENABLE];

	word_fifo u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.wr_valid(tx_fifo_en & in_valid),
		.wr_data(in_data),
		.wr_ready(fifo_ready),
		.rd_take(fifo_take_r),
		.rd_data(fifo_q),
		.rd_empty(fifo_empty)
	);

	// fifo prefetches one word into its output register
	always @(posedge core_clk) begin
		if (reset) begin
			fifo_take_r <= 1'b0;
			fifo_q_ok_r <= 1'b0;
		end else begin
			fifo_take_r <= ~fifo_empty & ~fifo_take_r & (~fifo_q_ok_r | (tx_load & tx_fifo_en));
			if (fifo_take_r) begin
				fifo_q_ok_r <= 1'b1;
			end else if (tx_load && tx_fifo_en) begin
				fifo_q_ok_r <= 1'b0;
			end
		end
	end

	assign tx_src_mux = tx_fifo_en ? fifo_q : in_data;
	// idle fill stays unwhitened so its leading one marks the first word for the receiver
	assign tx_load_word = (tx_fifo_en ? fifo_q_ok_r : in_valid) ?
		whiten(tx_src_mux, tx_cfg_r[`F_ENC_HI:`F_ENC_LO]) : `IDLE_FILL;

	always @(posedge core_clk) begin
		if (reset) begin
			tx_shift_r <= 40'h00_0000_0000;
			tx_cnt_r <= 6'h00;
			tx_busy_r <= 1'b0;
			ser_out <= 1'b0;
			tx_ready <= 1'b0;
			tx_divided_clock_out <= 1'b0;
			oob_cnt_r <= 8'h00;
		end else begin
			tx_ready <= tx_fifo_en ? fifo_ready : (tx_bit_en && tx_cnt_r == 6'h00);
			if (tx_cfg_r[`F_OOB]) begin
				// slow square bursts while high-speed data is off
				oob_cnt_r <= (oob_cnt_r == `OOB_HALF) ? 8'h00 : oob_cnt_r + 1'b1;
				if (tx_bit_en && oob_cnt_r == `OOB_HALF) begin
					ser_out <= ~ser_out;
				end
				tx_busy_r <= 1'b0;
				tx_cnt_r <= 6'h00;
			end else if (tx_load) begin
				if (tx_fifo_en ? fifo_q_ok_r : in_valid) begin
					tx_busy_r <= 1'b1;
				end else begin
					tx_busy_r <= 1'b0;
				end
				// first bit leaves in the load slot so every word gets exactly width bit slots
				ser_out <= tx_load_word[0];
				tx_shift_r <= {1'b0, tx_load_word[39:1]};
				tx_cnt_r <= tx_len - 1'b1;
				tx_divided_clock_out <= 1'b1;
			end else if (tx_bit_en) begin
				ser_out <= tx_shift_r[0];
				tx_shift_r <= {1'b0, tx_shift_r[39:1]};
				if (tx_cnt_r != 6'h00) begin
					tx_cnt_r <= tx_cnt_r - 1'b1;
				end
				if (tx_cnt_r == {1'b0, tx_len[5:1]} - 1'b1) begin
					tx_divided_clock_out <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// receive path
	// ----------------------------------------
	reg ser_meta_r;
	reg ser_sync_r;
	reg ser_prev_r;
	reg [4:0] phase_r;
	reg [39:0] rx_shift_r;
	reg [5:0] rx_cnt_r;
	reg [7:0] idle_cnt_r;
	wire [5:0] rx_len;
	wire [4:0] rx_mult;
	wire sample_now;

	assign rx_len = word_len(rx_cfg_r[`F_WIDTH_HI:`F_WIDTH_LO]);
	assign rx_mult = clamp_mult(rx_cfg_r[`F_MULT_HI:`F_MULT_LO]);
	assign sample_now = (phase_r == {1'b0, rx_mult[4:1]});

	always @(posedge core_clk) begin
		if (reset) begin
			ser_meta_r <= 1'b0;
			ser_sync_r <= 1'b0;
			ser_prev_r <= 1'b0;
			phase_r <= 5'h00;
			rx_shift_r <= 40'h00_0000_0000;
			rx_cnt_r <= 6'h00;
			rx_locked_r <= 1'b0;
			rx_oob_r <= 1'b0;
			idle_cnt_r <= 8'h00;
			rx_data <= 40'h00_0000_0000;
			rx_valid <= 1'b0;
			rx_user_clock <= 1'b0;
		end else begin
			ser_meta_r <= ser_in;
			ser_sync_r <= ser_meta_r;
			ser_prev_r <= ser_sync_r;
			rx_valid <= 1'b0;
			// edges realign the sampling phase to mid-bit
			if (ser_sync_r != ser_prev_r) begin
				phase_r <= 5'h01;
				rx_locked_r <= 1'b1;
				idle_cnt_r <= 8'h00;
			end else begin
				phase_r <= (phase_r >= rx_mult - 1'b1) ? 5'h00 : phase_r + 1'b1;
				if (rx_bit_en && idle_cnt_r != 8'hFF) begin
					idle_cnt_r <= idle_cnt_r + 1'b1;
				end
			end
			rx_oob_r <= (idle_cnt_r > `OOB_HALF) ? 1'b0 : rx_oob_r;
			if (rx_cfg_r[`F_OOB]) begin
				if (ser_sync_r != ser_prev_r) begin
					rx_oob_r <= 1'b1;
				end
			end else if (sample_now && rx_cfg_r[`F_ENABLE] && rx_locked_r) begin
				rx_shift_r <= {ser_sync_r, rx_shift_r[39:1]};
				if (rx_cnt_r == rx_len - 1'b1) begin
					rx_cnt_r <= 6'h00;
					// bits above the word width are cleared after undoing the whitening
					rx_data <= whiten({ser_sync_r, rx_shift_r[39:1]} >> (`LEN40 - rx_len),
						rx_cfg_r[`F_ENC_HI:`F_ENC_LO]) & ({40{1'b1}} >> (`LEN40 - rx_len));
					rx_valid <= 1'b1;
					rx_user_clock <= 1'b1;
				end else begin
					rx_cnt_r <= rx_cnt_r + 1'b1;
					if (rx_cnt_r == {1'b0, rx_len[5:1]}) begin
						rx_user_clock <= 1'b0;
					end
				end
			end
		end
	end
endmodule // serial_transceiver_datapath

// ===== serial_transceiver_datapath_tb_top.sv
/*
 * testbench: register access over wishbone and word loopback through the peer.
 * assumes the peer echoes the serial line and the checker is bound.
 */
`timescale 1ns/1ps
`include "xcvr_consts.vh"

module serial_transceiver_datapath_tb_top;
	reg core_clk = 1'b0;
	reg reset = 1'b1;
	reg wb_cyc_i = 1'b0;
	reg wb_stb_i = 1'b0;
	reg wb_we_i = 1'b0;
	reg [3:0] wb_adr_i = 4'h0;
	reg [3:0] wb_sel_i = 4'hF;
	reg [3:0] sel = 4'hF;
	reg [31:0] wb_dat_i = 32'h0000_0000;
	reg tx_valid = 1'b0;
	reg [39:0] tx_data = 40'h00_0000_0000;
	wire [31:0] wb_dat_o;
	wire [39:0] rx_data;
	wire wb_ack_o, tx_ready, tx_divided_clock_out, rx_valid, rx_user_clock, ser_out, ser_in;
	integer mismatches = 0;
	integer checked = 0;
	integer n, k, t, len;
	reg [31:0] rd, v, cfg, wm, tx_sh, rx_sh;
	reg [39:0] d, mask, idle_x;
	reg [39:0] sent_q[$];

	always #2.5 core_clk = ~core_clk;

	serial_transceiver_datapath u_dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.tx_divided_clock_out(tx_divided_clock_out), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_user_clock(rx_user_clock), .ser_out(ser_out), .ser_in(ser_in));
	remote_peer u_peer (.core_clk(core_clk), .reset(reset), .line_in(ser_out), .line_out(ser_in));

	task check(input string what, input [39:0] seen, input [39:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("mismatch %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task test_done;
		begin
			$display("counts checked %0d mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// one classic cycle, held until ack is sampled
	task wb_io(input we, input [3:0] adr, input [31:0] din);
		integer w;
		begin
			w = 0;
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= we;
			wb_adr_i <= adr;
			wb_sel_i <= sel;
			wb_dat_i <= din;
			@(posedge core_clk);
			while (wb_ack_o !== 1'b1 && w < 50) begin
				@(posedge core_clk);
				w = w + 1;
			end
			if (w >= 50)
				mismatches = mismatches + 1;
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	// idle fill as handed out after the receiver undoes the selected whitening
	function [39:0] idle_model(input [1:0] enc);
		begin
			case (enc)
				2'h0: idle_model = `IDLE_FILL;
				2'h1: idle_model = `IDLE_FILL ^ {4{`WHITEN_8B10B}};
				2'h2: idle_model = `IDLE_FILL ^ {`SCRAMBLE_SEED, `SCRAMBLE_SEED, `SCRAMBLE_LOW};
				default: idle_model = `IDLE_FILL ^ {`SCRAMBLE_LOW, `SCRAMBLE_SEED, `SCRAMBLE_SEED};
			endcase
		end
	endfunction

	// received words, idle fill skipped, compared in order
	always @(posedge core_clk) begin
		if (!reset && rx_valid === 1'b1 && sent_q.size() > 0 && rx_data !== idle_x)
			check("rx_word", rx_data, sent_q.pop_front());
	end

	initial begin
		#(5 * 70000);
		mismatches = mismatches + 1;
		test_done;
	end

	initial begin
		k = $urandom(11);
		mask = 40'hFF_FFFF_FFFF;
		idle_x = `IDLE_FILL;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		wb_io(1'b0, `REG_TX_CFG, 32'h0000_0000);
		check("tx_cfg_rst", rd, `CFG_RESET);
		wb_io(1'b0, `REG_RX_CFG, 32'h0000_0000);
		check("rx_cfg_rst", rd, `CFG_RESET);
		wb_io(1'b0, 4'h2, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		tx_sh = `CFG_RESET;
		rx_sh = `CFG_RESET;
		for (k = 0; k < 6; k = k + 1) begin
			v = (k == 0) ? 32'h0000_1F00 : (k == 1) ? 32'h0002_0000 : $urandom;
			sel = (k < 2) ? 4'hF : $urandom;
			wm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
			wb_io(1'b1, (k & 1) ? `REG_RX_CFG : `REG_TX_CFG, v);
			sel = 4'hF;
			wb_io(1'b0, (k & 1) ? `REG_RX_CFG : `REG_TX_CFG, 32'h0000_0000);
			if (k & 1) begin
				rx_sh = ((rx_sh & ~wm) | (v & wm)) & `CFG_MASK;
				check("rx_cfg_rw", rd, rx_sh);
			end else begin
				tx_sh = ((tx_sh & ~wm) | (v & wm)) & `CFG_MASK;
				check("tx_cfg_rw", rd, tx_sh);
			end
		end
		$display("test registers done");
		for (n = 0; n < 16; n = n + 1) begin
			reset <= 1'b1;
			@(posedge core_clk);
			reset <= 1'b0;
			@(posedge core_clk);
			cfg = 32'h0002_0000 | ((2 + $urandom % 3) << 8) | (((n ^ (n >> 2)) & 1) << 4) | (n & 15);
			wb_io(1'b1, `REG_TX_CFG, cfg);
			wb_io(1'b1, `REG_RX_CFG, cfg);
			len = (n % 4 == 0) ? 16 : (n % 4 == 1) ? 20 : (n % 4 == 2) ? 32 : 40;
			mask = (40'h1 << len) - 40'h1;
			idle_x = idle_model(n[3:2]) & mask;
			repeat (1000) @(posedge core_clk);
			for (k = 0; k < 4; k = k + 1) begin
				d = {$urandom, $urandom};
				tx_valid <= 1'b1;
				tx_data <= d;
				sent_q.push_back(d & mask);
				t = 0;
				@(posedge core_clk);
				while (tx_ready !== 1'b1 && t < 400) begin
					@(posedge core_clk);
					t = t + 1;
				end
				if (t >= 400)
					mismatches = mismatches + 1;
			end
			tx_valid <= 1'b0;
			repeat (1200) @(posedge core_clk);
			check("rx_left", sent_q.size(), 40'h00_0000_0000);
			sent_q.delete();
			wb_io(1'b0, `REG_STATUS, 32'h0000_0000);
			check("rx_locked", rd[3], 40'h00_0000_0001);
			check("fifo_drained", rd[2], 40'h00_0000_0001);
			$display("test loop %0d done", n);
		end
		test_done;
	end
endmodule // serial_transceiver_datapath_tb_top

// ===== word_fifo.v
/*
 * small single-clock word fifo with registered read data.
 * assumes one clock domain; writer checks full, reader checks empty.
 */
`timescale 1ns/1ps
`include "xcvr_consts.vh"

module word_fifo (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// write side
	input wire wr_valid,
	input wire [39:0] wr_data,
	output wire wr_ready,
	// read side
	input wire rd_take,
	output reg [39:0] rd_data,
	output wire rd_empty
);
	reg [39:0] mem [0:(1<<`FIFO_DEPTH_LOG2)-1];
	reg [`FIFO_DEPTH_LOG2:0] wp_r;
	reg [`FIFO_DEPTH_LOG2:0] rp_r;
	wire do_wr;
	wire do_rd;

	assign rd_empty = (wp_r == rp_r);
	assign wr_ready = ~((wp_r[`FIFO_DEPTH_LOG2] != rp_r[`FIFO_DEPTH_LOG2]) &&
		(wp_r[`FIFO_DEPTH_LOG2-1:0] == rp_r[`FIFO_DEPTH_LOG2-1:0]));
	assign do_wr = wr_valid & wr_ready;
	assign do_rd = rd_take & ~rd_empty;

	always @(posedge core_clk) begin
		if (do_wr) begin
			mem[wp_r[`FIFO_DEPTH_LOG2-1:0]] <= wr_data;
		end
		if (reset) begin
			wp_r <= {(`FIFO_DEPTH_LOG2+1){1'b0}};
			rp_r <= {(`FIFO_DEPTH_LOG2+1){1'b0}};
			rd_data <= 40'h00_0000_0000;
		end else begin
			if (do_wr) begin
				wp_r <= wp_r + 1'b1;
			end
			if (do_rd) begin
				rd_data <= mem[rp_r[`FIFO_DEPTH_LOG2-1:0]];
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule // word_fifo

// ===== xcvr_consts.vh
/*
 * constants for the serial transceiver datapath: register map, field positions,
 * reset values, word widths and encoding modes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef XCVR_CONSTS_VH
`define XCVR_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_TX_CFG 4'h0
`define REG_RX_CFG 4'h4
`define REG_STATUS 4'h8
`define REG_TX_WORD 4'hC

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define F_WIDTH_LO 0
`define F_WIDTH_HI 1
`define F_ENC_LO 2
`define F_ENC_HI 3
`define F_FIFO_EN 4
`define F_MULT_LO 8
`define F_MULT_HI 12
`define F_OOB 16
`define F_ENABLE 17
`define CFG_RESET 32'h0001_1400
`define CFG_MASK 32'h0003_1F1F

// ----------------------------------------
// word widths
// ----------------------------------------
`define W16 2'h0
`define W20 2'h1
`define W32 2'h2
`define W40 2'h3
`define LEN16 6'h10
`define LEN20 6'h14
`define LEN32 6'h20
`define LEN40 6'h28

// ----------------------------------------
// encodings and clocking
// ----------------------------------------
`define ENC_NONE 2'h0
`define ENC_8B10B 2'h1
`define ENC_64B66B 2'h2
`define ENC_64B67B 2'h3
`define MULT_MAX 5'h19
`define MULT_MIN 5'h01
`define SCRAMBLE_SEED 16'hACE1
`define SCRAMBLE_LOW 8'hE1
`define WHITEN_8B10B 10'h155
`define IDLE_FILL 40'h55_5555_5555
`define FIFO_DEPTH_LOG2 3
`define LANES 8
`define OOB_HALF 8'h20

`endif

// ===== xcvr_port_chk.sv
/*
 * port checker for one transceiver channel: wishbone answer timing,
 * receive word strobes, divided transmit clock and reset quiet state.
 * assumes it is bound onto serial_transceiver_datapath.
 */
`timescale 1ns/1ps

module xcvr_port_chk (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// word timing and serial line
	input wire tx_divided_clock_out,
	input wire rx_valid,
	input wire rx_user_clock,
	input wire ser_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence half_word_s;
		tx_divided_clock_out [*8];
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	ack_after_req_a: assert property (req_s |=> wb_ack_o) else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o || $past(reset)) else $error("read data moved without ack");
	rx_pulse_a: assert property (rx_valid |=> !rx_valid) else $error("rx word strobe too long");
	rx_clock_tie_a: assert property (rx_valid |-> $rose(rx_user_clock)) else $error("word without user clock rise");
	rx_rise_valid_a: assert property ($rose(rx_user_clock) |-> rx_valid) else $error("user clock rise without word");
	tx_clk_high_a: assert property ($rose(tx_divided_clock_out) |-> half_word_s) else $error("divided clock high too short");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !rx_valid && !ser_out
		&& !tx_divided_clock_out) else $error("outputs active after reset");
endmodule // xcvr_port_chk

bind serial_transceiver_datapath xcvr_port_chk u_chk (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_divided_clock_out(tx_divided_clock_out),
	.rx_valid(rx_valid), .rx_user_clock(rx_user_clock), .ser_out(ser_out));
